// file: include/azc_pkg.sv
// Constants for the offset calibration and interrupt enable register bank.
// Assumes a byte-wide register port decoded from the serial bus elsewhere.
//
// Functional notes
// - Start bit clear: every offset search begins from zero.
// - Start bit set: every offset search begins from the stored offset.
// - Interval field n runs calibration on every nth measurement cycle.
// - Interval zero never calibrates; all-ones calibrates only on the first cycle.
// - Enable bit 7 lets saturation drive the interrupt; resets to zero.
// - Enable bit 4 lets light threshold drive the interrupt; resets to zero.
package azc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] AZC_OFFSET_CAL_CONFIG_ADDR = 8'hD6;
  localparam logic [7:0] AZC_IRQ_SOURCE_ENABLE_ADDR = 8'hDD;
  localparam logic [7:0] AZC_OFFSET_CAL_CONFIG_RST = 8'h7F;
  localparam logic [7:0] AZC_IRQ_SOURCE_ENABLE_RST = 8'h00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AZC_SEARCH_START_BIT = 7;
  localparam int AZC_SAT_IEN_BIT = 7;
  localparam int AZC_LIGHT_IEN_BIT = 4;
  localparam logic [7:0] AZC_IEN_WRITABLE_MASK = 8'h90;
  localparam logic [6:0] AZC_INTERVAL_NEVER = 7'h00;
  localparam logic [6:0] AZC_INTERVAL_FIRST_ONLY = 7'h7F;
endpackage

// file: logic/azc_cycle_gate.sv
// Decides whether a measurement cycle carries an offset calibration.
// Assumes cycle_start_i is a one-cycle pulse from the sequencer, same clock.
`timescale 1ns/100ps
`default_nettype none
module azc_cycle_gate
  import azc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [6:0] interval_i,
  input wire logic cycle_start_i,
  input wire logic seq_restart_i,
  output logic cal_now_o
);
  // ----------------------------------------------------------------
  // Cycle counter
  // ----------------------------------------------------------------
  logic [6:0] count;
  logic first_pending;
  logic [6:0] next_count;
  logic next_first_pending;

  // Counter restarts with each new measurement sequence
  always_comb begin
    next_count = count;
    next_first_pending = first_pending;
    cal_now_o = 1'b0;
    if (seq_restart_i) begin
      next_count = 7'h00;
      next_first_pending = 1'b1;
    end else if (cycle_start_i) begin
      next_first_pending = 1'b0;
      if (interval_i == AZC_INTERVAL_NEVER) begin
        cal_now_o = 1'b0;
      end else if (interval_i == AZC_INTERVAL_FIRST_ONLY) begin
        cal_now_o = first_pending;
      end else if (count + 7'h01 >= interval_i) begin
        cal_now_o = 1'b1;
        next_count = 7'h00;
      end else begin
        next_count = count + 7'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      count <= 7'h00;
      first_pending <= 1'b1;
    end else begin
      count <= next_count;
      first_pending <= next_first_pending;
    end
  end
endmodule
`default_nettype wire

// file: logic/azc_regs.sv
// Offset calibration configuration and interrupt source enable registers.
// Assumes a byte register port from the serial bus decoder on core_clk_i.
`timescale 1ns/100ps
`default_nettype none
module azc_regs
  import azc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic cycle_start_i,
  input wire logic seq_restart_i,
  input wire logic [7:0] stored_offset_i,
  output logic cal_run_o,
  output logic [7:0] search_start_o,
  input wire logic saturation_event_i,
  input wire logic light_event_i,
  input wire logic status_clear_i,
  output logic saturation_flag_o,
  output logic light_flag_o,
  output logic irq_o
);
  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] offset_calibration_config;
  logic [7:0] interrupt_source_enable;
  logic [7:0] next_cfg;
  logic [7:0] next_ien;
  logic next_sat;
  logic next_light;
  logic cal_now;
  logic next_cal_run;
  logic [7:0] next_start;
  logic [7:0] next_rdata;

  logic offset_search_start_select;
  logic [6:0] offset_cal_interval;
  logic saturation_irq_enable;
  logic light_irq_enable;

  assign offset_search_start_select = offset_calibration_config[AZC_SEARCH_START_BIT];
  assign offset_cal_interval = offset_calibration_config[6:0];
  assign saturation_irq_enable = interrupt_source_enable[AZC_SAT_IEN_BIT];
  assign light_irq_enable = interrupt_source_enable[AZC_LIGHT_IEN_BIT];

  // Register writes; reserved enable bits are kept at zero whatever is written
  always_comb begin
    next_cfg = offset_calibration_config;
    next_ien = interrupt_source_enable;
    if (reg_wr_i && reg_addr_i == AZC_OFFSET_CAL_CONFIG_ADDR) begin
      next_cfg = reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == AZC_IRQ_SOURCE_ENABLE_ADDR) begin
      next_ien = reg_wdata_i & AZC_IEN_WRITABLE_MASK;
    end
  end

  // Readback registered so the bus decoder sees a glitch-free byte;
  // the data follows the address one edge later, unmapped addresses read zero
  always_comb begin
    unique case (reg_addr_i)
      AZC_OFFSET_CAL_CONFIG_ADDR: next_rdata = offset_calibration_config;
      AZC_IRQ_SOURCE_ENABLE_ADDR: next_rdata = interrupt_source_enable;
      default: next_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Calibration request toward the sequencer
  // ----------------------------------------------------------------
  azc_cycle_gate u_gate (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .interval_i(offset_cal_interval),
    .cycle_start_i(cycle_start_i),
    .seq_restart_i(seq_restart_i),
    .cal_now_o(cal_now)
  );

  // Start value latched with the request so it stays stable for the search
  always_comb begin
    next_cal_run = cal_now;
    next_start = search_start_o;
    if (cal_now) begin
      if (offset_search_start_select) begin
        next_start = stored_offset_i;
      end else begin
        next_start = 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags and interrupt
  // ----------------------------------------------------------------
  // Flags update even when masked; a new event wins over a same-cycle clear
  always_comb begin
    next_sat = saturation_flag_o;
    next_light = light_flag_o;
    if (status_clear_i) begin
      next_sat = 1'b0;
      next_light = 1'b0;
    end
    if (saturation_event_i) begin
      next_sat = 1'b1;
    end
    if (light_event_i) begin
      next_light = 1'b1;
    end
  end

  // Combinational so the pin follows a clear on the very next edge
  assign irq_o = (saturation_flag_o & saturation_irq_enable)
               | (light_flag_o & light_irq_enable);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      offset_calibration_config <= AZC_OFFSET_CAL_CONFIG_RST;
      interrupt_source_enable <= AZC_IRQ_SOURCE_ENABLE_RST;
      saturation_flag_o <= 1'b0;
      light_flag_o <= 1'b0;
      cal_run_o <= 1'b0;
      search_start_o <= 8'h00;
      reg_rdata_o <= 8'h00;
    end else begin
      offset_calibration_config <= next_cfg;
      interrupt_source_enable <= next_ien;
      saturation_flag_o <= next_sat;
      light_flag_o <= next_light;
      cal_run_o <= next_cal_run;
      search_start_o <= next_start;
      reg_rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_zero_start;
    @(posedge core_clk_i) disable iff (srst_i)
    (cal_now && !offset_search_start_select) |=> (cal_run_o && search_start_o == 8'h00);
  endproperty
  a_zero_start: assert property (p_zero_start) else $error("search start not zero");

  property p_prev_start;
    @(posedge core_clk_i) disable iff (srst_i)
    (cal_now && offset_search_start_select) |=> (search_start_o == $past(stored_offset_i));
  endproperty
  a_prev_start: assert property (p_prev_start) else $error("search start not stored");

  property p_never;
    @(posedge core_clk_i) disable iff (srst_i)
    (offset_cal_interval == AZC_INTERVAL_NEVER) |-> !cal_now;
  endproperty
  a_never: assert property (p_never) else $error("calibration with interval zero");

  property p_every_one;
    @(posedge core_clk_i) disable iff (srst_i)
    (cycle_start_i && !seq_restart_i && offset_cal_interval == 7'h01) |-> cal_now;
  endproperty
  a_every_one: assert property (p_every_one) else $error("interval one missed cycle");

  property p_no_cal_without_cycle;
    @(posedge core_clk_i) disable iff (srst_i)
    !cycle_start_i |-> ##1 !cal_run_o;
  endproperty
  a_no_cal_without_cycle: assert property (p_no_cal_without_cycle) else $error("stray calibration");

  property p_sat_irq;
    @(posedge core_clk_i) disable iff (srst_i)
    (saturation_event_i && saturation_irq_enable && !(reg_wr_i && reg_addr_i == AZC_IRQ_SOURCE_ENABLE_ADDR)) |=> irq_o;
  endproperty
  a_sat_irq: assert property (p_sat_irq) else $error("saturation irq missing");

  property p_light_irq;
    @(posedge core_clk_i) disable iff (srst_i)
    (light_event_i && light_irq_enable && !(reg_wr_i && reg_addr_i == AZC_IRQ_SOURCE_ENABLE_ADDR)) |=> irq_o;
  endproperty
  a_light_irq: assert property (p_light_irq) else $error("light irq missing");

  property p_masked_flag;
    @(posedge core_clk_i) disable iff (srst_i)
    saturation_event_i |=> saturation_flag_o;
  endproperty
  a_masked_flag: assert property (p_masked_flag) else $error("flag not set");

  property p_reserved_zero;
    @(posedge core_clk_i) disable iff (srst_i)
    (interrupt_source_enable & ~AZC_IEN_WRITABLE_MASK) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved enable bits set");

  // A clear with no competing event in the same cycle
  sequence s_clear_only;
    status_clear_i && !saturation_event_i && !light_event_i;
  endsequence

  property p_light_flag;
    @(posedge core_clk_i) disable iff (srst_i)
    light_event_i |=> light_flag_o;
  endproperty
  a_light_flag: assert property (p_light_flag) else $error("light flag not set");

  property p_flag_clear;
    @(posedge core_clk_i) disable iff (srst_i)
    s_clear_only |=> (!saturation_flag_o && !light_flag_o);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared");

  // The sequencer may read the start value at any time during the search
  property p_start_hold;
    @(posedge core_clk_i) disable iff (srst_i)
    !cal_now |=> $stable(search_start_o);
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("search start moved");

  property p_cal_from_cycle;
    @(posedge core_clk_i) disable iff (srst_i)
    cal_run_o |-> ($past(cycle_start_i) && !$past(seq_restart_i));
  endproperty
  a_cal_from_cycle: assert property (p_cal_from_cycle) else $error("calibration without cycle");
endmodule
`default_nettype wire

// file: testbench/azc_seq_model.sv
// Measurement sequencer stand-in: issues cycle start pulses.
// Assumes the same clock and synchronous reset as the register bank.
`timescale 1ns/100ps
`default_nettype none
module azc_seq_model (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic run_i,
  input wire logic [3:0] gap_i,
  output logic cycle_start_o
);
  logic [3:0] wait_q;
  // --------------------------------
  // Pulse generator
  // --------------------------------
  // Gap zero gives back-to-back starts, the hardest case for the counter
  always @(posedge core_clk_i) begin
    if (srst_i || !run_i) begin
      cycle_start_o <= 1'b0;
      wait_q <= 4'h0;
    end else if (wait_q >= gap_i) begin
      cycle_start_o <= 1'b1;
      wait_q <= 4'h0;
    end else begin
      cycle_start_o <= 1'b0;
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the calibration and interrupt enable registers.
// Assumes azc_pkg compiled first and the sequencer model beside it.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import azc_pkg::*;
  logic core_clk_i = 0, srst_i = 1, wr = 0, rst_seq = 0, sat = 0, lit = 0, clr = 0, run = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, offs = 8'h00, cfg = 8'h7F, rdata, start;
  logic [3:0] gap = 4'h0;
  logic cal, cyc, sflag, lflag, irq, first = 1;
  int n_errors = 0, comparisons = 0, ticks = 0, cnt = 0, seed = 32'h9436135F;
  logic [7:0] expq[$];
  logic [7:0] cfgs[7] = '{8'h7F, 8'h01, 8'h83, 8'h05, 8'h00, 8'hFF, 8'h02};
  logic [7:0] ens[4] = '{8'h00, 8'h80, 8'h10, 8'h90};
  azc_regs dut_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .reg_wr_i(wr),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .cycle_start_i(cyc),
    .seq_restart_i(rst_seq), .stored_offset_i(offs), .cal_run_o(cal), .search_start_o(start),
    .saturation_event_i(sat), .light_event_i(lit), .status_clear_i(clr),
    .saturation_flag_o(sflag), .light_flag_o(lflag), .irq_o(irq));
  azc_seq_model seq_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .run_i(run), .gap_i(gap),
    .cycle_start_o(cyc));
  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    if (a == AZC_OFFSET_CAL_CONFIG_ADDR) cfg = d;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    addr <= a;
    @(posedge core_clk_i);
    #1 check(rdata, exp);
  endtask
  task pulse(input logic s, input logic l, input logic c);
    @(posedge core_clk_i);
    sat <= s;
    lit <= l;
    clr <= c;
    @(posedge core_clk_i);
    {sat, lit, clr} <= 3'b000;
    #1;
  endtask
  // --------------------------------
  // Expected calibrations, noted as cycles start
  // --------------------------------
  // Cycle ceiling: all scenarios together need well under a thousand cycles
  always @(posedge core_clk_i) begin
    ticks++;
    if (ticks > 2000) begin
      n_errors++;
      stop_test;
    end
  end
  always @(posedge core_clk_i) begin
    if (srst_i) cfg = AZC_OFFSET_CAL_CONFIG_RST;
    if (srst_i || rst_seq) begin
      cnt = 0;
      first = 1;
    end else if (cyc) begin
      if (cfg[6:0] == AZC_INTERVAL_FIRST_ONLY) begin
        if (first) expq.push_back(cfg[7] ? offs : 8'h00);
      end else if (cfg[6:0] != AZC_INTERVAL_NEVER) begin
        cnt++;
        if (cnt == int'(cfg[6:0])) begin
          cnt = 0;
          expq.push_back(cfg[7] ? offs : 8'h00);
        end
      end
      first = 0;
    end
  end
  // Watcher: every calibration pulse must match the oldest note
  always @(posedge core_clk_i) begin
    if (cal === 1'b1) begin
      if (expq.size() == 0) check(8'h01, 8'h00);
      else check(start, expq.pop_front());
    end
  end
  initial begin
    repeat (3) @(posedge core_clk_i);
    srst_i <= 1'b0;
    rd_reg(AZC_OFFSET_CAL_CONFIG_ADDR, 8'h7F);
    rd_reg(AZC_IRQ_SOURCE_ENABLE_ADDR, 8'h00);
    rd_reg(8'h80, 8'h00);
    // Interval cases, restarting the sequence after each write
    foreach (cfgs[i]) begin
      if (i > 0) wr_reg(AZC_OFFSET_CAL_CONFIG_ADDR, cfgs[i]);
      rd_reg(AZC_OFFSET_CAL_CONFIG_ADDR, cfgs[i]);
      @(posedge core_clk_i);
      rst_seq <= 1'b1;
      offs <= 8'($random(seed));
      gap <= {2'b00, 2'($random(seed))};
      @(posedge core_clk_i);
      rst_seq <= 1'b0;
      run <= 1'b1;
      repeat (60) @(posedge core_clk_i);
      run <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      check(8'(expq.size()), 8'h00);
    end
    // Reserved enable bits read back as zero even when written as ones
    wr_reg(AZC_IRQ_SOURCE_ENABLE_ADDR, 8'hFF);
    rd_reg(AZC_IRQ_SOURCE_ENABLE_ADDR, 8'h90);
    foreach (ens[i]) begin
      wr_reg(AZC_IRQ_SOURCE_ENABLE_ADDR, ens[i]);
      pulse(1'b1, 1'b0, 1'b0);
      check({sflag, lflag, irq}, {2'b10, ens[i][7]});
      pulse(1'b0, 1'b1, 1'b0);
      check({sflag, lflag, irq}, {2'b11, ens[i][7] | ens[i][4]});
      pulse(1'b1, 1'b0, 1'b1);
      check({sflag, lflag, irq}, {2'b10, ens[i][7]});
      pulse(1'b0, 1'b0, 1'b1);
      check({sflag, lflag, irq}, 8'h00);
    end
    // Mid-run reset brings registers and flags back to their reset state
    wr_reg(AZC_IRQ_SOURCE_ENABLE_ADDR, 8'h90);
    pulse(1'b1, 1'b1, 1'b0);
    check({sflag, lflag, irq}, 8'h07);
    @(posedge core_clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    srst_i <= 1'b0;
    #1 check({sflag, lflag, irq}, 8'h00);
    rd_reg(AZC_OFFSET_CAL_CONFIG_ADDR, 8'h7F);
    rd_reg(AZC_IRQ_SOURCE_ENABLE_ADDR, 8'h00);
    stop_test;
  end
endmodule
`default_nettype wire
